// file: include/sarcs_pkg.sv
// Purpose: Constants for the successive-approximation conversion sequencer
// Assumes: 100 MHz core clock
// Notes: Times in ns, counts derived from the clock period
package sarcs_pkg;
	localparam int SARCS_BITS = 16;
	localparam int SARCS_CLK_NS = 10;
	// Conversion slot for 250 kSPS: 4000 ns per sample
	localparam int SARCS_PERIOD_NS = 4000;
	// Settling time of each switch step and of each trial
	localparam int SARCS_SWITCH_NS = 20;
	localparam int SARCS_TRIAL_NS = 100;
	localparam int SARCS_SWITCH_CYC =
		(SARCS_SWITCH_NS + SARCS_CLK_NS - 1) / SARCS_CLK_NS;
	localparam int SARCS_TRIAL_CYC =
		(SARCS_TRIAL_NS + SARCS_CLK_NS - 1) / SARCS_CLK_NS;
	localparam logic [15:0] SARCS_CODE_ZERO = 16'h0000;
	localparam logic [15:0] SARCS_CODE_FULL = 16'hFFFF;
	localparam logic [15:0] SARCS_CODE_MID = 16'h8000;
	localparam logic [7:0] SARCS_CNT_RST = 8'h00;
	typedef enum logic [2:0] {
		SARCS_ACQ,
		SARCS_OPEN_GND,
		SARCS_TO_GND,
		SARCS_TRIAL,
		SARCS_DONE
	} sarcs_state_t;
endpackage

// file: rtl/sarcs_sequencer.sv
// Purpose: Sequences sampling switches and the 16-step bit search
// Assumes: Comparator and convert_start come from outside; both synced here
// Notes: Serial readout is outside; it uses result and done_pulse
//
// Contract
// - Rising convert_start ends acquisition, starts conversion, holds sample.
// - Ground switches open first, then the arrays move from inputs to ground.
// - Sixteen binary trials, half reference down to 1/65536, MSB first.
// - After the search, power down, reacquire, present code, signal done.
// - Conversion is timed from the internal clock, no serial clock needed.
// - The result is 16-bit straight binary.
// - Overrange input saturates to all ones.
// - Underrange input clamps to all zeros.
// - The result belongs to the conversion just finished, no latency.
// - Up to 250 kSPS, with power down between conversions.
// - When enabled, done shows as a start bit ahead of the data.
`timescale 1ns/1ps
module sarcs_sequencer import sarcs_pkg::*; #(
	parameter int BITS = SARCS_BITS
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Host and analog side inputs
	input wire logic convert_start,
	input wire logic comp_high,
	input wire logic busy_ind_en,
	// Analog switch controls
	output logic pos_ground_switch,
	output logic neg_ground_switch,
	output logic arrays_to_ground,
	output logic [BITS-1:0] dac_trial,
	output logic powered_up,
	// Result
	output logic [BITS-1:0] result,
	output logic done_pulse,
	output logic start_bit
);
	sarcs_state_t state_q;
	logic [1:0] cnv_sync_q;
	logic cnv_prev_q;
	logic [1:0] cmp_sync_q;
	logic [7:0] cnt_q;
	logic [4:0] bit_q;
	logic [BITS-1:0] sar_q;
	logic cnv_rise;
	logic [8:0] busy_cyc_q;

	function automatic logic [BITS-1:0] onehot(input logic [4:0] idx);
		onehot = '0;
		onehot[idx[3:0]] = 1'b1;
	endfunction

	assign cnv_rise = cnv_sync_q[1] & ~cnv_prev_q;

	// Input synchronisers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnv_sync_q <= 2'h0;
			cnv_prev_q <= 1'b0;
			cmp_sync_q <= 2'h0;
		end else if (clk_en) begin
			cnv_sync_q <= {cnv_sync_q[0], convert_start};
			cnv_prev_q <= cnv_sync_q[1];
			cmp_sync_q <= {cmp_sync_q[0], comp_high};
		end
	end

	// Sequence, timed from core clock only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= SARCS_ACQ;
			cnt_q <= SARCS_CNT_RST;
			bit_q <= 5'h0;
			sar_q <= SARCS_CODE_ZERO;
		end else if (clk_en) begin
			case (state_q)
				SARCS_ACQ: begin
					if (cnv_rise) begin
						state_q <= SARCS_OPEN_GND;
						cnt_q <= 8'(SARCS_SWITCH_CYC - 1);
					end
				end
				SARCS_OPEN_GND: begin
					if (cnt_q == 8'h00) begin
						state_q <= SARCS_TO_GND;
						cnt_q <= 8'(SARCS_SWITCH_CYC - 1);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				SARCS_TO_GND: begin
					if (cnt_q == 8'h00) begin
						state_q <= SARCS_TRIAL;
						cnt_q <= 8'(SARCS_TRIAL_CYC - 1);
						bit_q <= 5'(BITS - 1);
						sar_q <= SARCS_CODE_MID;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				SARCS_TRIAL: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						// Comparator high means trial exceeds input: drop bit
						if (cmp_sync_q[1]) begin
							sar_q <= sar_q & ~onehot(bit_q);
						end
						if (bit_q == 5'h0) begin
							state_q <= SARCS_DONE;
						end else begin
							sar_q[bit_q[3:0] - 4'h1] <= 1'b1;
							bit_q <= bit_q - 5'h1;
							cnt_q <= 8'(SARCS_TRIAL_CYC - 1);
						end
					end
				end
				SARCS_DONE: state_q <= SARCS_ACQ;
				default: state_q <= SARCS_ACQ;
			endcase
		end
	end

	// Switch and power outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pos_ground_switch <= 1'b1;
			neg_ground_switch <= 1'b1;
			arrays_to_ground <= 1'b0;
			dac_trial <= SARCS_CODE_ZERO;
			powered_up <= 1'b0;
		end else if (clk_en) begin
			// Ground switches closed only while acquiring
			pos_ground_switch <= (state_q == SARCS_ACQ) & ~cnv_rise;
			neg_ground_switch <= (state_q == SARCS_ACQ) & ~cnv_rise;
			arrays_to_ground <= (state_q == SARCS_TO_GND) |
				(state_q == SARCS_TRIAL);
			dac_trial <= (state_q == SARCS_TRIAL) ? sar_q : SARCS_CODE_ZERO;
			// Powered only while converting
			powered_up <= (state_q != SARCS_ACQ) & (state_q != SARCS_DONE);
		end
	end

	// Result capture; search bounds give clamping at both ends
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			result <= SARCS_CODE_ZERO;
			done_pulse <= 1'b0;
			start_bit <= 1'b0;
		end else if (clk_en) begin
			done_pulse <= (state_q == SARCS_DONE);
			if (state_q == SARCS_DONE) begin
				result <= sar_q;
				start_bit <= busy_ind_en;
			end else if (cnv_rise && state_q == SARCS_ACQ) begin
				start_bit <= 1'b0;
			end
		end
	end

	// Enabled cycles of one powered conversion, for timing checks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_cyc_q <= 9'h000;
		end else if (clk_en) begin
			if (powered_up) begin
				busy_cyc_q <= busy_cyc_q + 9'h001;
			end else begin
				busy_cyc_q <= 9'h000;
			end
		end
	end

	sarcs_fsm_a: assert property (
		@(posedge core_clk) disable iff (rst)
		clk_en && cnv_rise && state_q == SARCS_ACQ |=>
		state_q == SARCS_OPEN_GND) else $error("No start");
	switch_order_a: assert property (
		@(posedge core_clk) disable iff (rst)
		arrays_to_ground |-> !pos_ground_switch && !neg_ground_switch)
		else $error("Arrays grounded with switches closed");
	msb_first_a: assert property (
		@(posedge core_clk) disable iff (rst)
		clk_en && state_q == SARCS_TO_GND && cnt_q == 8'h00 |=>
		sar_q == SARCS_CODE_MID && bit_q == 5'hF)
		else $error("Search not MSB first");
	done_result_a: assert property (
		@(posedge core_clk) disable iff (rst)
		clk_en && state_q == SARCS_DONE |=>
		done_pulse && result == $past(sar_q))
		else $error("Result not from this conversion");
	power_down_a: assert property (
		@(posedge core_clk) disable iff (rst)
		done_pulse |-> !powered_up)
		else $error("Not powered down");
	result_hold_a: assert property (
		@(posedge core_clk) disable iff (rst)
		!done_pulse && $past(!done_pulse) |-> $stable(result))
		else $error("Result changed");
	bit_low_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_q == SARCS_TRIAL |-> bit_q <= 5'hF && sar_q[bit_q[3:0]] &&
		(sar_q & (onehot(bit_q) - BITS'(1))) == '0)
		else $error("Trial bit or lower bits wrong");
	start_bit_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(done_pulse) |-> start_bit == $past(busy_ind_en))
		else $error("Start bit wrong");
	trial_drive_a: assert property (
		@(posedge core_clk) disable iff (rst)
		clk_en && state_q == SARCS_TRIAL |=> dac_trial == $past(sar_q))
		else $error("Trial code not driven");
	powered_conv_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_q == SARCS_TRIAL |-> powered_up && arrays_to_ground)
		else $error("Search without power or grounded arrays");
	done_once_a: assert property (
		@(posedge core_clk) disable iff (rst)
		done_pulse && clk_en |=> !done_pulse)
		else $error("Done longer than one cycle");
	conv_time_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(done_pulse) |->
		busy_cyc_q == 9'(2 * SARCS_SWITCH_CYC + BITS * SARCS_TRIAL_CYC))
		else $error("Conversion length wrong");
	rate_slot_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(done_pulse) |->
		busy_cyc_q <= 9'(SARCS_PERIOD_NS / SARCS_CLK_NS))
		else $error("Conversion longer than the sample slot");
	freeze_hold_a: assert property (
		@(posedge core_clk) disable iff (rst)
		!clk_en |=> $stable(state_q) && $stable(sar_q) && $stable(result))
		else $error("State moved while clock enable low");
	conv_cov: cover property (@(posedge core_clk) done_pulse);
	full_cov: cover property (@(posedge core_clk)
		done_pulse && result == SARCS_CODE_FULL);
	zero_cov: cover property (@(posedge core_clk)
		done_pulse && result == SARCS_CODE_ZERO);
	mid_cov: cover property (@(posedge core_clk)
		done_pulse && result == SARCS_CODE_MID);
	busy_cov: cover property (@(posedge core_clk)
		done_pulse && start_bit);
endmodule

// file: testbench/sarcs_comparator_model.sv
// Purpose: Comparator with the held input sample
// Assumes: Bench sets level, held through a conversion
// Notes: Level beyond 0..FFFF gives over- and underrange
`timescale 1ns/1ps
module sarcs_comparator_model (
	// Search side
	input wire logic [15:0] dac_trial,
	input wire logic arrays_to_ground,
	input wire logic signed [17:0] level,
	// Comparator
	output logic comp_high
);
	// Trial above sample drops the bit
	assign comp_high = arrays_to_ground && ($signed({2'b0, dac_trial}) > level);
endmodule

// file: testbench/tb_sar_conversion_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Comparator model stands for the analog side
// Notes: One task per scenario
`timescale 1ns/1ps
module tb_sar_conversion_sequencer;
	import sarcs_pkg::*;
	logic core_clk, rst, clk_en, convert_start, busy_ind_en, comp_high;
	logic pos_ground_switch, neg_ground_switch, arrays_to_ground;
	logic powered_up, done_pulse, start_bit;
	logic [15:0] dac_trial, result, prev;
	logic signed [17:0] level;
	int failures, compares, cycles;
	sarcs_sequencer dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.convert_start(convert_start), .comp_high(comp_high),
		.busy_ind_en(busy_ind_en), .pos_ground_switch(pos_ground_switch),
		.neg_ground_switch(neg_ground_switch),
		.arrays_to_ground(arrays_to_ground), .dac_trial(dac_trial),
		.powered_up(powered_up), .result(result),
		.done_pulse(done_pulse), .start_bit(start_bit));
	sarcs_comparator_model model (.dac_trial(dac_trial),
		.arrays_to_ground(arrays_to_ground), .level(level),
		.comp_high(comp_high));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic final_report;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			$display("CHECK FAILED %0t timeout", $time);
			final_report;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task automatic convert(input logic signed [17:0] lvl, input logic en);
		int n;
		logic [15:0] exp;
		exp = lvl < 0 ? 16'h0000 : lvl > 18'sh0FFFF ? 16'hFFFF : lvl[15:0];
		@(posedge core_clk);
		level <= lvl;
		busy_ind_en <= en;
		convert_start <= 1'b1;
		n = 0;
		while (pos_ground_switch !== 1'b0 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk1(neg_ground_switch, 1'b0);
		chk1(arrays_to_ground, 1'b0);
		chk(result, prev);
		@(posedge core_clk);
		convert_start <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk1(arrays_to_ground, 1'b1);
		chk1(powered_up, 1'b1);
		chk(dac_trial, SARCS_CODE_MID);
		while (done_pulse !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(result, exp);
		chk1(start_bit, en);
		@(posedge core_clk);
		#1;
		chk1(done_pulse, 1'b0);
		chk1(powered_up, 1'b0);
		chk1(pos_ground_switch, 1'b1);
		chk1(arrays_to_ground, 1'b0);
		chk(dac_trial, SARCS_CODE_ZERO);
		prev = exp;
	endtask
	task automatic t_codes;
		logic signed [17:0] v[8] = '{18'sh0, 18'sh1, 18'sh07FFF, 18'sh08000,
			18'sh08001, 18'sh0FFFF, 18'sh10000, -18'sh1};
		foreach (v[i]) convert(v[i], i[0]);
	endtask
	task automatic t_hold;
		repeat (60) @(posedge core_clk);
		#1;
		chk(result, prev);
		chk1(powered_up, 1'b0);
	endtask
	task automatic t_freeze;
		@(posedge core_clk);
		clk_en <= 1'b0;
		convert_start <= 1'b1;
		repeat (10) @(posedge core_clk);
		convert_start <= 1'b0;
		repeat (5) @(posedge core_clk);
		clk_en <= 1'b1;
		repeat (10) @(posedge core_clk);
		#1;
		chk1(powered_up, 1'b0);
		chk1(pos_ground_switch, 1'b1);
		chk(result, prev);
	endtask
	initial begin
		rst <= 1'b1;
		clk_en <= 1'b1;
		convert_start <= 1'b0;
		busy_ind_en <= 1'b0;
		level <= '0;
		prev = '0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_codes;
		t_freeze;
		t_hold;
		final_report;
	end
endmodule
